// file: bench/fcs_props.sv
/*
 Port checks for the start-up sequencer.
 Assumes one core_clk domain, synchronous active-low rst_n.
*/
`timescale 1ns/100ps
module fcs_props (
  input wire core_clk,
  input wire rst_n,
  input wire program_n_pin,
  input wire done_pin_in,
  input wire init_pin_oe_r,
  input wire done_pin_oe_r,
  input wire dout_r,
  input wire opt_gated_start,
  input wire [1:0] opt_tap_done,
  input wire [1:0] opt_tap_io,
  input wire [1:0] opt_tap_gsr,
  input wire high_during_config_r,
  input wire low_during_config_n_r,
  input wire user_io_active_r,
  input wire global_set_reset_hold_r,
  input wire clear_active_r,
  input wire frame_wr_valid_r,
  input wire frame_error_r,
  input wire cfg_complete_r
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_init_prog;
    !program_n_pin [*3] |=> init_pin_oe_r;
  endproperty
  a_init_prog: assert property (p_init_prog) else $error("init late");
  property p_status;
    !user_io_active_r |-> high_during_config_r && !low_during_config_n_r;
  endproperty
  a_status: assert property (p_status) else $error("status pins");
  property p_clear_reset;
    clear_active_r [*3] |-> init_pin_oe_r && done_pin_oe_r &&
      global_set_reset_hold_r && !cfg_complete_r && !user_io_active_r;
  endproperty
  a_clear_reset: assert property (p_clear_reset) else $error("clr");
  property p_err;
    $rose(frame_error_r) |-> ##[0:2] init_pin_oe_r;
  endproperty
  a_err: assert property (p_err) else $error("error without init");
  property p_dout;
    frame_wr_valid_r |-> dout_r;
  endproperty
  a_dout: assert property (p_dout) else $error("dout low in frame");
  property p_order_io;
    $rose(user_io_active_r) && opt_tap_done < opt_tap_io |-> !done_pin_oe_r;
  endproperty
  a_order_io: assert property (p_order_io) else $error("io early");
  property p_order_gsr;
    $fell(global_set_reset_hold_r) && opt_tap_io < opt_tap_gsr
      |-> user_io_active_r;
  endproperty
  a_order_gsr: assert property (p_order_gsr) else $error("gsr early");
  property p_gated;
    (!done_pin_in) [*4] ##0 (opt_gated_start && opt_tap_io == 2'h3 &&
      !user_io_active_r) |=> !user_io_active_r;
  endproperty
  a_gated: assert property (p_gated) else $error("stall broken");
  c_done: cover property ($rose(cfg_complete_r));
  c_err: cover property ($rose(frame_error_r));
  c_stall: cover property (opt_gated_start && !done_pin_in);
endmodule

bind fcs_sequencer fcs_props fcs_props_i (
  .core_clk(core_clk), .rst_n(rst_n), .program_n_pin(program_n_pin),
  .done_pin_in(done_pin_in), .init_pin_oe_r(init_pin_oe_r),
  .done_pin_oe_r(done_pin_oe_r), .dout_r(dout_r),
  .opt_gated_start(opt_gated_start), .opt_tap_done(opt_tap_done),
  .opt_tap_io(opt_tap_io), .opt_tap_gsr(opt_tap_gsr),
  .high_during_config_r(high_during_config_r),
  .low_during_config_n_r(low_during_config_n_r),
  .user_io_active_r(user_io_active_r),
  .global_set_reset_hold_r(global_set_reset_hold_r),
  .clear_active_r(clear_active_r), .frame_wr_valid_r(frame_wr_valid_r),
  .frame_error_r(frame_error_r), .cfg_complete_r(cfg_complete_r));

// file: bench/fcs_source.sv
/*
 Serial slave-mode configuration source.
 Assumes go pulses with len, data and bad steady until busy falls.
*/
`timescale 1ns/100ps
`include "fcs_map.vh"
module fcs_source #(
  parameter NF = 2,
  parameter FB = 8
) (
  input wire go,
  input wire bad,
  input wire hold,
  input wire [23:0] len,
  input wire [15:0] data,
  output reg config_clock,
  output reg din,
  output reg busy
);
  integer i;
  integer f;
  reg [3:0] pre;
  reg [3:0] chk;
  // ------------------------------------------------------------
  // One clock per bit, idle low between streams
  // ------------------------------------------------------------
  task send(input b);
    begin
      din = b;
      #16;
      while (hold) #4;
      config_clock = 1'b1;
      #16;
      config_clock = 1'b0;
    end
  endtask
  initial begin
    config_clock = 1'b0;
    din = 1'b0;
    busy = 1'b0;
  end
  always @(posedge go) begin
    busy = 1'b1;
    pre = `FCS_PREAMBLE;
    chk = bad ? ~`FCS_ERR_PATTERN : `FCS_ERR_PATTERN;
    for (i = 0; i < 4; i = i + 1) send(1'b1);
    for (i = 3; i >= 0; i = i - 1) send(pre[i]);
    for (i = 23; i >= 0; i = i - 1) send(len[i]);
    for (f = 0; f < NF; f = f + 1) begin
      send(1'b1);
      send(1'b0);
      for (i = 0; i < FB; i = i + 1) send(data[f*FB+i]);
      for (i = 3; i >= 0; i = i - 1) send(chk[i]);
    end
    for (i = 0; i < 8; i = i + 1) send(1'b1);
    din = ~din;
    busy = 1'b0;
  end
endmodule

// file: bench/fpga_config_startup_sequencer_bench.sv
/*
 Self-checking bench for the start-up sequencer in slave mode.
 Assumes the source model on the link; bench drives wire pull-downs.
*/
`timescale 1ns/100ps
module fpga_config_startup_sequencer_bench;
  localparam NF = 2;
  localparam FB = 8;
  reg core_clk, rst_n, program_n_pin, ext_init, ext_done, user_clk;
  reg opt_user_clock, opt_gated_start, frame_wr_ready, go, bad, stall, pace;
  reg [2:0] mode;
  reg [1:0] tap_d, tap_i, tap_g;
  reg [15:0] data;
  wire init_oe, done_oe, config_clock, din, busy, dout, high_during_config, ldc_n, io, global_set_reset_hold, clr;
  wire fwv, fwd, ferr, cmpl, room, cko, ckoe, fast;
  wire [2:0] cfg_mode;
  wire init_w = !init_oe && !ext_init;
  wire done_w = !done_oe && !ext_done;
  integer seed, mismatches, checked, cyc, n;
  reg q[$];
  function [23:0] exp_len(input integer nf, input integer fb);
    exp_len = 32 + nf * (fb + 6);
  endfunction
  fcs_sequencer #(.POR_CYCLES(32'h32), .INIT_WAIT_CYCLES(32'h14),
    .NUM_FRAMES(16'h2), .FRAME_BITS(16'h8), .OSC_DIV(16'h8),
    .SLOW_HALF(16'h8)) fcs_sequencer_i (
    .core_clk(core_clk), .rst_n(rst_n), .program_n_pin(program_n_pin),
    .init_pin_in(init_w), .init_pin_oe_r(init_oe), .done_pin_in(done_w),
    .done_pin_oe_r(done_oe), .mode_select(mode), .config_clock_in(config_clock),
    .config_clock_out_r(cko), .config_clock_oe_r(ckoe), .din(din),
    .dout_r(dout),
    .user_startup_clock(user_clk), .opt_user_clock(opt_user_clock),
    .opt_gated_start(opt_gated_start), .opt_tap_done(tap_d),
    .opt_tap_io(tap_i), .opt_tap_gsr(tap_g), .high_during_config_r(high_during_config),
    .low_during_config_n_r(ldc_n), .user_io_active_r(io),
    .global_set_reset_hold_r(global_set_reset_hold), .clear_active_r(clr),
    .frame_wr_valid_r(fwv), .frame_wr_data_r(fwd),
    .frame_wr_ready(frame_wr_ready), .cfg_mode_r(cfg_mode),
    .fast_rate_r(fast), .frame_error_r(ferr), .cfg_complete_r(cmpl),
    .fifo_room_r(room));
  fcs_source #(.NF(NF), .FB(FB)) fcs_source_i (.go(go), .bad(bad),
    .hold(!room && pace), .len(exp_len(NF, FB)), .data(data),
    .config_clock(config_clock), .din(din), .busy(busy));
  // ------------------------------------------------------------
  // Clocks, monitor, watchdog
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    user_clk = 1'b0;
    forever #20 user_clk = ~user_clk;
  end
  always @(negedge core_clk) begin
    frame_wr_ready <= stall ? 1'b0 : (($random(seed) & 3) != 0);
    if (fwv === 1'b1) begin
      check(q.size() > 0, 1, "extra");
      if (q.size() > 0) check(fwd, q.pop_front(), "bit");
    end
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches = mismatches + 1;
      tally_and_finish;
    end
  end
  task check(input [7:0] seen, input [7:0] exp, input [8*6:1] what);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task wait_clear;
    begin
      n = 0;
      while (clr !== 1'b0) begin
        @(negedge core_clk);
        n = n + 1;
      end
    end
  endtask
  task load(input b);
    integer j;
    begin
      data = $random(seed);
      for (j = 0; j < NF * FB; j = j + 1)
        if (!b || j < FB) q.push_back(data[j]);
      bad = b;
      go = 1'b1;
      @(negedge core_clk);
      go = 1'b0;
      while (!b && fwv !== 1'b1) @(negedge core_clk);
      stall = !b;
      pace = !b;
      while (!b && room !== 1'b0) @(negedge core_clk);
      if (!b) check(room, 0, "full");
      repeat (40) @(negedge core_clk);
      stall = 1'b0;
      while (room !== 1'b1 && !b) @(negedge core_clk);
      pace = 1'b0;
      while (busy) @(negedge core_clk);
      repeat (30) @(negedge core_clk);
      check(q.size(), 0, "bits");
    end
  endtask
  task pgm;
    begin
      program_n_pin = 1'b0;
      repeat (5) @(negedge core_clk);
      check({init_oe, clr, cmpl, done_oe, global_set_reset_hold}, 8'h1B, "pgm");
      repeat (40) @(negedge core_clk);
      check(clr, 1, "hold");
      program_n_pin = 1'b1;
      wait_clear;
      check(n >= 16 && n < 50, 1, "reclr");
      repeat (30) @(negedge core_clk);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    seed = 81367;
    {mismatches, checked, cyc} = 0;
    {rst_n, ext_done, go, bad, stall, pace, opt_user_clock} = 0;
    {opt_gated_start, frame_wr_ready} = 0;
    {program_n_pin, ext_init} = 2'h3;
    {tap_d, tap_i, tap_g} = {2'h1, 2'h2, 2'h3};
    mode = $random(seed) | 3'h1;
    repeat (4) @(negedge core_clk);
    check({init_oe, done_oe, high_during_config, ldc_n, io, global_set_reset_hold, clr, dout}, 8'hE7, "rst");
    rst_n = 1'b1;
    wait_clear;
    check(n >= 50, 1, "por");
    repeat (30) @(negedge core_clk);
    check({init_oe, cfg_mode}, 0, "held");
    ext_init = 1'b0;
    repeat (10) @(negedge core_clk);
    check(cfg_mode, mode, "mode");
    $display("test power-up done");
    load(1'b0);
    check({cmpl, done_oe, io, global_set_reset_hold, high_during_config, ldc_n}, 8'h29, "start");
    check({ckoe, cko, fast}, 0, "slave");
    $display("test load done");
    pgm;
    load(1'b1);
    check({ferr, init_oe, cmpl}, 8'h6, "ferr");
    $display("test error done");
    {opt_user_clock, opt_gated_start, ext_done} = 3'h7;
    {tap_d, tap_i, tap_g} = {2'h2, 2'h3, 2'h1};
    pgm;
    load(1'b0);
    check({done_oe, global_set_reset_hold, io}, 0, "stall");
    ext_done = 1'b0;
    repeat (60) @(negedge core_clk);
    check(io, 1, "go_io");
    $display("test gated done");
    tally_and_finish;
  end
endmodule

// file: rtl/fcs_map.vh
/*
 Constants for the configuration start-up sequencer: timing counts,
 bitstream fields and start-up tap defaults.
 Assumes a 250 MHz core clock and plain `define use by includers.
*/
`ifndef FCS_MAP_VH
`define FCS_MAP_VH
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define FCS_CLK_PERIOD_NS 4
`define FCS_POR_TIME_NS 16000000
`define FCS_POR_CYCLES (`FCS_POR_TIME_NS / `FCS_CLK_PERIOD_NS)
`define FCS_MASTER_POR_MULT 4
`define FCS_INIT_WAIT_NS 50000
`define FCS_INIT_WAIT_CYCLES \
  ((`FCS_INIT_WAIT_NS + `FCS_CLK_PERIOD_NS - 1) / `FCS_CLK_PERIOD_NS)
`define FCS_MODE_DELAY 2'h2
`define FCS_OSC_DIV 16'h0008
`define FCS_SLOW_HALF 16'h0040
`define FCS_FAST_FACTOR 16'h0008
`define FCS_EXTRA_CLOCKS 3'h4
// ------------------------------------------------------------
// Bitstream
// ------------------------------------------------------------
`define FCS_PREAMBLE 4'h2
`define FCS_LEN_BITS 24
`define FCS_ERR_BITS 4
`define FCS_ERR_PATTERN 4'h6
`define FCS_RATE_BIT_POS 16'h0001
`define FCS_NUM_FRAMES 16'h0010
`define FCS_FRAME_BITS 16'h0020
`define FCS_FIFO_DEPTH 4
// ------------------------------------------------------------
// Start-up taps
// ------------------------------------------------------------
`define FCS_TAP_DONE 2'h1
`define FCS_TAP_IO 2'h2
`define FCS_TAP_GSR 2'h3
`define FCS_SU_SYNC_STAGE 3
`endif

// file: rtl/fcs_sequencer.v
/*
 Configuration start-up sequencer with its bit FIFO: memory clear,
 initialisation handshake, preamble and length parsing, frame loading,
 daisy-chain output and the five-stage start-up register.
 Assumes pins arrive asynchronously to core_clk and that the frame
 memory accepts bits under frame_wr_ready.
*/
// Functional notes
// - Clear frames on oscillator while power-on delay runs or reconfig held
// - Each pass end checks delay and request; one more pass then init
// - From reset drive low_during_config, init, done low; high_during high
// - Release init pin only after the last clearing pass
// - Master waits 50-250 us of init high before taking it inactive
// - Two clocks after init high, sample the three mode pins
// - Source sends 0010 then 24-bit length; store as clock count
// - Four configuration clocks beyond length count finish configuration; code sets cfg_complete_r on the fifth
// - Daisy output high while loading own frames, then forward data
// - Master clocks slow until rate bit decoded; fast is eightfold
// - Frame is start, data, error field; error halts, init low
// - Request released: one more clear, then start unless init held
// - Reconfiguration request low forces init output low
// - External init low delays; mode pins captured after release
// - Start-up when memory full and clock count equals length
// - Next clock edge sets stage 0 of 5-bit start-up register
// - Register taps release done, activate user I/O, end set/reset
// - The three events may be ordered in any sequence by option
// - Default: done first, I/O one clock later, set/reset one more
// - Stages after first clocked by config clock or user clock
// - Gated mode: wire-ANDed done pin feeds stage 3, stalls start-up
// - With config clock, stages zero through three give all timing
// - Power-up only clear delay 16 ms, four times in master mode
// - Clock counter starts on the very first configuration clock
`timescale 1ns/100ps
`include "fcs_map.vh"

module fcs_fifo #(
  parameter W = 1,
  parameter D = `FCS_FIFO_DEPTH,
  parameter AW = 2
) (
  input wire core_clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_r [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rp_r];
  always @(posedge core_clk) begin
    if (push)
      mem_r[wp_r] <= in_data;
  end
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wp_r <= (wp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      if (pop)
        rp_r <= (rp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

module fcs_sequencer #(
  parameter [31:0] POR_CYCLES = `FCS_POR_CYCLES,
  parameter [31:0] INIT_WAIT_CYCLES = `FCS_INIT_WAIT_CYCLES,
  parameter [15:0] NUM_FRAMES = `FCS_NUM_FRAMES,
  parameter [15:0] FRAME_BITS = `FCS_FRAME_BITS,
  parameter [15:0] OSC_DIV = `FCS_OSC_DIV,
  parameter [15:0] SLOW_HALF = `FCS_SLOW_HALF
) (
  input wire core_clk,
  input wire rst_n,
  input wire program_n_pin,
  input wire init_pin_in,
  output reg init_pin_oe_r,
  input wire done_pin_in,
  output reg done_pin_oe_r,
  input wire [2:0] mode_select,
  input wire config_clock_in,
  output reg config_clock_out_r,
  output reg config_clock_oe_r,
  input wire din,
  output reg dout_r,
  input wire user_startup_clock,
  input wire opt_user_clock,
  input wire opt_gated_start,
  input wire [1:0] opt_tap_done,
  input wire [1:0] opt_tap_io,
  input wire [1:0] opt_tap_gsr,
  output reg high_during_config_r,
  output reg low_during_config_n_r,
  output reg user_io_active_r,
  output reg global_set_reset_hold_r,
  output reg clear_active_r,
  output reg frame_wr_valid_r,
  output reg frame_wr_data_r,
  input wire frame_wr_ready,
  output reg [2:0] cfg_mode_r,
  output reg fast_rate_r,
  output reg frame_error_r,
  output reg cfg_complete_r,
  output reg fifo_room_r
);
  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam [8:0] ST_CLEAR = 9'h001;
  localparam [8:0] ST_LAST = 9'h002;
  localparam [8:0] ST_INITW = 9'h004;
  localparam [8:0] ST_MODE = 9'h008;
  localparam [8:0] ST_PRE = 9'h010;
  localparam [8:0] ST_LEN = 9'h020;
  localparam [8:0] ST_FRAME = 9'h040;
  localparam [8:0] ST_PASS = 9'h080;
  localparam [8:0] ST_ERR = 9'h100;
  localparam [15:0] FAST_HALF = SLOW_HALF / `FCS_FAST_FACTOR;

  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  reg [1:0] prog_sy_r, init_sy_r, done_sy_r, config_clock_sy_r, din_sy_r;
  reg [1:0] uclk_sy_r;
  reg [2:0] mode_sy0_r, mode_sy1_r;
  reg config_clock_d_r, uclk_d_r;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      prog_sy_r <= 2'h0;
      init_sy_r <= 2'h0;
      done_sy_r <= 2'h0;
      config_clock_sy_r <= 2'h0;
      din_sy_r <= 2'h0;
      uclk_sy_r <= 2'h0;
      mode_sy0_r <= 3'h0;
      mode_sy1_r <= 3'h0;
      config_clock_d_r <= 1'b0;
      uclk_d_r <= 1'b0;
    end else begin
      prog_sy_r <= {prog_sy_r[0], program_n_pin};
      init_sy_r <= {init_sy_r[0], init_pin_in};
      done_sy_r <= {done_sy_r[0], done_pin_in};
      config_clock_sy_r <= {config_clock_sy_r[0], config_clock_in};
      din_sy_r <= {din_sy_r[0], din};
      uclk_sy_r <= {uclk_sy_r[0], user_startup_clock};
      mode_sy0_r <= mode_select;
      mode_sy1_r <= mode_sy0_r;
      config_clock_d_r <= config_clock_sy_r[1];
      uclk_d_r <= uclk_sy_r[1];
    end
  end
  wire prog_s = prog_sy_r[1];
  wire init_s = init_sy_r[1];
  wire done_s = done_sy_r[1];
  wire din_s = din_sy_r[1];
  wire uclk_edge = uclk_sy_r[1] & ~uclk_d_r;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [8:0] st_r;
  reg por_busy_r, master_r, last_r, start_hit_r;
  reg [31:0] tmr_r;
  reg [15:0] osc_r, clr_frame_r, div_r, bitc_r, frame_idx_r;
  reg [23:0] len_r, clk_cnt_r;
  reg [3:0] pre_sh_r, err_sh_r;
  reg [1:0] fph_r;
  reg [4:0] su_r;
  reg [2:0] extra_r;
  wire fifo_in_ready, fifo_out_valid, fifo_bit;

  // ------------------------------------------------------------
  // Configuration clock
  // ------------------------------------------------------------
  wire loading = |(st_r & (ST_PRE | ST_LEN | ST_FRAME));
  wire cfg_run = |(st_r & (ST_PRE | ST_LEN | ST_FRAME | ST_PASS));
  wire [15:0] half = fast_rate_r ? FAST_HALF : SLOW_HALF;
  wire div_hit = (div_r >= half - 16'h0001);
  // Master stalls its own clock while the FIFO is full
  wire m_edge = master_r & cfg_run & ~cfg_complete_r & div_hit &
                ~config_clock_out_r & fifo_in_ready;
  wire s_edge = ~master_r & cfg_run & config_clock_sy_r[1] & ~config_clock_d_r;
  wire cfg_edge = m_edge | s_edge;
  wire su_edge = opt_user_clock ? uclk_edge : cfg_edge;
  wire pop = fifo_out_valid & frame_wr_ready;
  wire osc_tick = (osc_r == OSC_DIV - 16'h0001);
  wire pass_end = osc_tick & (clr_frame_r == NUM_FRAMES - 16'h0001);
  wire [31:0] por_lim = master_r ?
    POR_CYCLES * `FCS_MASTER_POR_MULT : POR_CYCLES;

  fcs_fifo #(
    .W(1),
    .D(`FCS_FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(cfg_edge & loading),
    .in_ready(fifo_in_ready),
    .in_data(din_s),
    .out_valid(fifo_out_valid),
    .out_ready(frame_wr_ready),
    .out_data(fifo_bit)
  );

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= ST_CLEAR;
      por_busy_r <= 1'b1;
      master_r <= 1'b0;
      tmr_r <= 32'h0000_0000;
      osc_r <= 16'h0000;
      clr_frame_r <= 16'h0000;
      div_r <= 16'h0000;
      bitc_r <= 16'h0000;
      frame_idx_r <= 16'h0000;
      len_r <= 24'h00_0000;
      clk_cnt_r <= 24'h00_0000;
      pre_sh_r <= 4'hF;
      err_sh_r <= 4'h0;
      fph_r <= 2'h0;
      last_r <= 1'b0;
      config_clock_out_r <= 1'b0;
      config_clock_oe_r <= 1'b0;
      dout_r <= 1'b1;
      cfg_mode_r <= 3'h0;
      fast_rate_r <= 1'b0;
      frame_error_r <= 1'b0;
      frame_wr_valid_r <= 1'b0;
      frame_wr_data_r <= 1'b0;
      clear_active_r <= 1'b1;
      fifo_room_r <= 1'b0;
    end else begin
      frame_wr_valid_r <= 1'b0;
      fifo_room_r <= fifo_in_ready & loading;
      master_r <= (st_r == ST_CLEAR || st_r == ST_LAST) ?
                  ~mode_sy1_r[0] : master_r;
      if (por_busy_r)
        tmr_r <= tmr_r + 32'h0000_0001;
      if (por_busy_r && tmr_r >= por_lim) begin
        por_busy_r <= 1'b0;
        tmr_r <= 32'h0000_0000;
      end
      osc_r <= osc_tick ? 16'h0000 : osc_r + 16'h0001;
      // Master clock divider
      if (master_r && cfg_run && !cfg_complete_r) begin
        config_clock_oe_r <= 1'b1;
        if (div_hit && (config_clock_out_r || fifo_in_ready)) begin
          div_r <= 16'h0000;
          config_clock_out_r <= ~config_clock_out_r;
        end else if (!div_hit) begin
          div_r <= div_r + 16'h0001;
        end
      end else begin
        div_r <= 16'h0000;
        config_clock_out_r <= 1'b0;
        config_clock_oe_r <= master_r & cfg_run;
      end
      if (cfg_edge)
        clk_cnt_r <= clk_cnt_r + 24'h00_0001;
      // Daisy chain output
      if (cfg_edge) begin
        if (st_r == ST_PRE || st_r == ST_LEN || st_r == ST_PASS)
          dout_r <= din_s;
        else
          dout_r <= 1'b1;
      end
      if (!prog_s && st_r != ST_CLEAR) begin
        st_r <= ST_CLEAR;
        clr_frame_r <= 16'h0000;
        clk_cnt_r <= 24'h00_0000;
        len_r <= 24'h00_0000;
        last_r <= 1'b0;
        clear_active_r <= 1'b1;
      end else begin
        case (st_r)
          ST_CLEAR: begin
            clear_active_r <= 1'b1;
            if (osc_tick)
              clr_frame_r <= pass_end ? 16'h0000 :
                             clr_frame_r + 16'h0001;
            if (pass_end && !por_busy_r && prog_s)
              st_r <= ST_LAST;
          end
          ST_LAST: begin
            if (osc_tick)
              clr_frame_r <= pass_end ? 16'h0000 :
                             clr_frame_r + 16'h0001;
            if (pass_end) begin
              st_r <= ST_INITW;
              clear_active_r <= 1'b0;
              tmr_r <= 32'h0000_0000;
            end
          end
          ST_INITW: begin
            // Held low from outside: keep waiting
            if (!init_s)
              tmr_r <= 32'h0000_0000;
            else if (!master_r || tmr_r >= INIT_WAIT_CYCLES) begin
              st_r <= ST_MODE;
              tmr_r <= 32'h0000_0000;
            end else
              tmr_r <= tmr_r + 32'h0000_0001;
          end
          ST_MODE: begin
            tmr_r <= tmr_r + 32'h0000_0001;
            if (tmr_r[1:0] == `FCS_MODE_DELAY - 2'h1) begin
              cfg_mode_r <= mode_sy1_r;
              master_r <= ~mode_sy1_r[0];
              st_r <= ST_PRE;
              clk_cnt_r <= 24'h00_0000;
              pre_sh_r <= 4'hF;
              fast_rate_r <= 1'b0;
              frame_idx_r <= 16'h0000;
              last_r <= 1'b0;
            end
          end
          ST_PRE: begin
            if (pop) begin
              pre_sh_r <= {pre_sh_r[2:0], fifo_bit};
              if ({pre_sh_r[2:0], fifo_bit} == `FCS_PREAMBLE) begin
                st_r <= ST_LEN;
                bitc_r <= 16'h0000;
              end
            end
          end
          ST_LEN: begin
            if (pop) begin
              len_r <= {len_r[22:0], fifo_bit};
              bitc_r <= bitc_r + 16'h0001;
              if (bitc_r == `FCS_LEN_BITS - 1) begin
                st_r <= ST_FRAME;
                fph_r <= 2'h0;
              end
            end
          end
          ST_FRAME: begin
            if (pop) begin
              case (fph_r)
                2'h0: begin
                  if (!fifo_bit) begin
                    fph_r <= 2'h1;
                    bitc_r <= 16'h0000;
                  end
                end
                2'h1: begin
                  frame_wr_valid_r <= 1'b1;
                  frame_wr_data_r <= fifo_bit;
                  if (master_r && frame_idx_r == 16'h0000 &&
                      bitc_r == `FCS_RATE_BIT_POS)
                    fast_rate_r <= ~fifo_bit;
                  bitc_r <= bitc_r + 16'h0001;
                  if (bitc_r == FRAME_BITS - 16'h0001) begin
                    fph_r <= 2'h2;
                    bitc_r <= 16'h0000;
                  end
                end
                2'h2: begin
                  err_sh_r <= {err_sh_r[2:0], fifo_bit};
                  bitc_r <= bitc_r + 16'h0001;
                  if (bitc_r == `FCS_ERR_BITS - 1) begin
                    fph_r <= 2'h0;
                    if ({err_sh_r[2:0], fifo_bit} != `FCS_ERR_PATTERN) begin
                      st_r <= ST_ERR;
                      frame_error_r <= 1'b1;
                    end else if (frame_idx_r == NUM_FRAMES - 16'h0001) begin
                      st_r <= ST_PASS;
                      last_r <= 1'b1;
                    end else
                      frame_idx_r <= frame_idx_r + 16'h0001;
                  end
                end
                default: fph_r <= 2'h0;
              endcase
            end
          end
          ST_PASS: st_r <= ST_PASS;
          ST_ERR: st_r <= ST_ERR;
          default: st_r <= ST_CLEAR;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Start-up register
  // ------------------------------------------------------------
  wire su_clear = (st_r == ST_CLEAR);
  wire [4:1] su_nxt;
  genvar k;
  generate
    for (k = 1; k < 5; k = k + 1) begin : g_stage
      wire gate = (k == `FCS_SU_SYNC_STAGE) ?
                  (~opt_gated_start | done_s) : 1'b1;
      assign su_nxt[k] = (su_edge && gate) ?
                         su_r[k-1] : su_r[k];
    end
  endgenerate

  always @(posedge core_clk) begin
    if (!rst_n) begin
      start_hit_r <= 1'b0;
      su_r <= 5'h00;
      extra_r <= 3'h0;
      cfg_complete_r <= 1'b0;
    end else if (su_clear) begin
      start_hit_r <= 1'b0;
      su_r <= 5'h00;
      extra_r <= 3'h0;
      cfg_complete_r <= 1'b0;
    end else begin
      start_hit_r <= last_r & (clk_cnt_r == len_r);
      su_r[4:1] <= su_nxt;
      if (cfg_edge && start_hit_r)
        su_r[0] <= 1'b1;
      if (cfg_edge && su_r[0] && !cfg_complete_r) begin
        extra_r <= extra_r + 3'h1;
        if (extra_r == `FCS_EXTRA_CLOCKS - 3'h1)
          cfg_complete_r <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Status pins
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      init_pin_oe_r <= 1'b1;
      done_pin_oe_r <= 1'b1;
      high_during_config_r <= 1'b1;
      low_during_config_n_r <= 1'b0;
      user_io_active_r <= 1'b0;
      global_set_reset_hold_r <= 1'b1;
    end else begin
      init_pin_oe_r <= ~prog_s | clear_active_r |
                       (st_r == ST_ERR);
      done_pin_oe_r <= ~su_r[opt_tap_done];
      user_io_active_r <= su_r[opt_tap_io];
      global_set_reset_hold_r <= ~su_r[opt_tap_gsr];
      high_during_config_r <= ~su_r[opt_tap_io];
      low_during_config_n_r <= su_r[opt_tap_io];
    end
  end
endmodule
